// ### pin_source.sv
// Purpose: Far-side model driving the timer pin and the external interrupt line
// Assumes: Driven from the bench clock; pin is a plain level, no pull
// Notes:   half of zero holds the pin at lvl, else it toggles every half cycles
`timescale 1ns/1ps
module pin_source (
    input  wire logic       pclk,
    input  wire logic [7:0] half,
    input  wire logic       lvl,
    input  wire logic       irq_on,
    output      logic       timer_pin,
    output      logic       ext_irq_n
);
    logic [7:0] cnt;

    initial begin
        cnt = 8'h00;
        timer_pin = 1'b0;
    end

    always @(posedge pclk) begin
        if (half == 8'h00) begin
            timer_pin <= lvl;
            cnt <= 8'h00;
        end else if (cnt == half - 8'h01) begin
            timer_pin <= ~timer_pin;
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    assign ext_irq_n = ~irq_on;
endmodule

// ### pin_sync.sv
// Purpose: Two flip-flop synchroniser for a group of pins
// Assumes: Pins are asynchronous to pclk
// Notes:   Output is the second stage only
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] rst_val,
    output      logic [W-1:0] pin_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_out = sync_q & ~rst_val | sync_q & rst_val;
endmodule

// ### timer_irq.sv
// Purpose: Down-counting timer, interrupt vectoring, wait and stop modes
// Assumes: Core reaches it over APB; timer and irq pins are asynchronous
// Notes:   Service points are signalled by the core through commands
// Contract
// - Writable 8-bit counter decrements per selected clock
// - Reaching zero sets request flag bit 7
// - Timer interrupt only when both masks are clear; external needs only the global mask clear
// - Timer vector 1FF8, or 1FF6 leaving wait
// - Counter wraps and keeps counting past zero
// - Counter readable any time without disturbance
// - Request flag sticky; software sets or clears
// - Three low bits pick prescaler tap
// - Writing bit 3 set clears prescaler
// - Prescaler clear bit always reads zero
// - Source and pin bits select timer input
// - Internal clock keeps running during wait
// - Power-on and stop load counter with F0
// - Resets and stop clear request flag
// - Resets and stop set mask flag
// - Resets keep source, pin and tap bits; power-on reset loads them with zero (TCR 40)
// - Wait halts everything except the timer
// - Wait drives strobes low, direction high
// - Wait clears global mask, exits on interrupt
// - External first; later timer uses normal vector
// - Trap ignores mask, vectors through 1FFC
// - External reset sets mask, vectors 1FFE
// - Masked requests latch until mask clears
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module timer_irq (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    input  wire logic        timer_pin,
    input  wire logic        ext_irq_n,
    input  wire logic        ext_reset_n,
    output      logic        core_irq,
    output      logic        core_run,
    output      logic [15:0] vec_addr,
    output      logic        vec_strobe,
    output      logic        addr_strobe,
    output      logic        data_strobe,
    output      logic        bus_rw,
    output      logic        bus_oe
);
    timer_irq_pkg::tcr_t  tcr_q;
    timer_irq_pkg::tcr_t  tcr_d;
    timer_irq_pkg::mode_t state_q;
    timer_irq_pkg::mode_t state_d;
    logic [7:0]  count_q;
    logic [7:0]  count_d;
    logic [2:0]  cyc_q;
    logic        cyc_clk;
    logic        in_prev_q;
    logic        in_level;
    logic        in_fall;
    logic        tick;
    logic        gmask_q;
    logic        gmask_d;
    logic        ext_latch_q;
    logic        ext_latch_d;
    logic        map64_q;
    logic [15:0] vec_q;
    logic [15:0] vec_base;
    logic [3:0]  vec_low;
    logic        vec_stb_q;
    logic        irq_q;
    logic        run_q;
    logic        as_q;
    logic        ds_q;
    logic        rw_q;
    logic        oe_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        ready_q;
    logic        err_q;
    logic [2:0]  sync_out;
    logic        pin_s;
    logic        irq_n_s;
    logic        xrst_n_s;
    logic        xrst_prev_q;
    logic        xrst_go;
    logic        acc;
    logic        wr;
    logic        wr_tc;
    logic        wr_cnt;
    logic        wr_sys;
    logic        wr_cfg;
    logic        mapped;
    logic        wait_go;
    logic        stop_go;
    logic        trap_go;
    logic        done_go;
    logic        tmr_pend;
    logic        svc_ext;
    logic        svc_tmr;
    logic        svc_go;
    logic        zero_evt;
    logic        ld_cnt;

    pin_sync #(.W(3)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  ({timer_pin, ext_irq_n, ext_reset_n}),
        .rst_val (3'h7),
        .pin_out (sync_out)
    );
    assign pin_s    = sync_out[2];
    assign irq_n_s  = sync_out[1];
    assign xrst_n_s = sync_out[0];
    assign xrst_go  = !xrst_n_s && xrst_prev_q;

    // APB decode; writes act at the edge where pready is seen high
    assign acc    = psel && penable;
    assign wr     = acc && ready_q && pwrite;
    assign mapped = (paddr == timer_irq_pkg::ADDR_TCTRL) || (paddr == timer_irq_pkg::ADDR_COUNT)
                 || (paddr == timer_irq_pkg::ADDR_SYS) || (paddr == timer_irq_pkg::ADDR_VECTOR)
                 || (paddr == timer_irq_pkg::ADDR_CONFIG);
    assign wr_tc  = wr && (paddr == timer_irq_pkg::ADDR_TCTRL);
    assign wr_cnt = wr && (paddr == timer_irq_pkg::ADDR_COUNT);
    assign wr_sys = wr && (paddr == timer_irq_pkg::ADDR_SYS);
    assign wr_cfg = wr && (paddr == timer_irq_pkg::ADDR_CONFIG);

    assign wait_go = wr_sys && pwdata[timer_irq_pkg::CMD_WAIT] && (state_q == timer_irq_pkg::ST_RUN);
    assign stop_go = wr_sys && pwdata[timer_irq_pkg::CMD_STOP] && (state_q == timer_irq_pkg::ST_RUN);
    assign trap_go = wr_sys && pwdata[timer_irq_pkg::CMD_TRAP] && !xrst_go;
    assign done_go = wr_sys && pwdata[timer_irq_pkg::CMD_DONE];

    // Internal cycle clock is never gated by wait
    assign cyc_clk = (cyc_q < timer_irq_pkg::CYC_HI);

    // Input source selection
    assign in_level = tcr_q.tmr_src_select ? (tcr_q.tmr_pin_enable & pin_s)
                    : (tcr_q.tmr_pin_enable ? (cyc_clk & pin_s) : cyc_clk);
    assign in_fall  = in_prev_q && !in_level && (state_q != timer_irq_pkg::ST_STOP);

    tmr_prescaler u_presc (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (wr_tc && pwdata[timer_irq_pkg::TC_CLEAR]),
        .in_fall (in_fall),
        .sel     (tcr_q.prescale_sel),
        .tick    (tick)
    );

    // Counter load, decrement and wrap
    assign ld_cnt   = wr_cnt;
    assign zero_evt = tick && !ld_cnt && (count_q == 8'h01);
    assign count_d  = stop_go ? timer_irq_pkg::COUNT_LOAD
                    : ld_cnt ? pwdata[7:0]
                    : tick ? count_q - 8'h01
                    : count_q;

    // Pending sources and service selection
    assign tmr_pend = tcr_q.tmr_req_flag && !tcr_q.tmr_mask_flag;
    assign svc_ext  = ext_latch_q && !gmask_q && (done_go || state_q != timer_irq_pkg::ST_RUN);
    assign svc_tmr  = tmr_pend && !ext_latch_q && !gmask_q
                   && (done_go || state_q == timer_irq_pkg::ST_WAIT);
    assign svc_go   = !xrst_go && !stop_go && (svc_ext || svc_tmr || trap_go);
    assign vec_base = map64_q ? timer_irq_pkg::BASE_64K : timer_irq_pkg::BASE_8K;
    assign vec_low  = xrst_go ? timer_irq_pkg::VEC_RESET
                    : trap_go ? timer_irq_pkg::VEC_TRAP
                    : svc_ext ? timer_irq_pkg::VEC_EXT
                    : (state_q == timer_irq_pkg::ST_WAIT) ? timer_irq_pkg::VEC_TWAIT
                    : timer_irq_pkg::VEC_TIMER;

    // Control register next value; hardware set wins over a software write, stop and external reset clear win over the set
    always_comb begin
        tcr_d = tcr_q;
        if (wr_tc) begin
            tcr_d = timer_irq_pkg::tcr_t'(pwdata[7:0]);
            tcr_d.prescale_clear = 1'b0;
        end
        if (zero_evt) begin
            tcr_d.tmr_req_flag = 1'b1;
        end
        if (xrst_go || stop_go) begin
            tcr_d.tmr_req_flag  = 1'b0;
            tcr_d.tmr_mask_flag = 1'b1;
            tcr_d.tmr_src_select = tcr_q.tmr_src_select;
            tcr_d.tmr_pin_enable = tcr_q.tmr_pin_enable;
            tcr_d.prescale_sel   = tcr_q.prescale_sel;
        end
    end

    // Global mask and external latch
    always_comb begin
        gmask_d = gmask_q;
        if (wr_sys && pwdata[timer_irq_pkg::CMD_CLI]) begin
            gmask_d = 1'b0;
        end
        if (wr_sys && pwdata[timer_irq_pkg::CMD_SEI]) begin
            gmask_d = 1'b1;
        end
        if (wait_go) begin
            gmask_d = 1'b0;
        end
        if (svc_go || xrst_go) begin
            gmask_d = 1'b1;
        end
        ext_latch_d = (ext_latch_q && !(svc_go && svc_ext && !trap_go)) || !irq_n_s;
        if (xrst_go) begin
            ext_latch_d = 1'b0;
        end
    end

    // Mode sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            timer_irq_pkg::ST_RUN: begin
                if (stop_go) begin
                    state_d = timer_irq_pkg::ST_STOP;
                end else if (wait_go) begin
                    state_d = timer_irq_pkg::ST_WAIT;
                end
            end
            timer_irq_pkg::ST_WAIT, timer_irq_pkg::ST_STOP: begin
                if (svc_go || ext_latch_q || xrst_go) begin
                    state_d = timer_irq_pkg::ST_RUN;
                end
            end
        endcase
        if (xrst_go) begin
            state_d = timer_irq_pkg::ST_RUN;
        end
    end

    // Read data
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (paddr)
            timer_irq_pkg::ADDR_TCTRL:  rdata_d[7:0]  = tcr_q & 8'hf7;
            timer_irq_pkg::ADDR_COUNT:  rdata_d[7:0]  = count_q;
            timer_irq_pkg::ADDR_SYS:    rdata_d[4:0]  = {irq_q, ext_latch_q,
                                                         state_q == timer_irq_pkg::ST_STOP,
                                                         state_q == timer_irq_pkg::ST_WAIT, gmask_q};
            timer_irq_pkg::ADDR_VECTOR: rdata_d[15:0] = vec_q;
            timer_irq_pkg::ADDR_CONFIG: rdata_d[0]    = map64_q;
            default:                    rdata_d       = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcr_q       <= timer_irq_pkg::tcr_t'(8'h40);
            count_q     <= timer_irq_pkg::COUNT_LOAD;
            state_q     <= timer_irq_pkg::ST_RUN;
            gmask_q     <= 1'b1;
            ext_latch_q <= 1'b0;
            map64_q     <= 1'b0;
            in_prev_q   <= 1'b0;
            xrst_prev_q <= 1'b1;
            cyc_q       <= 3'h0;
        end else begin
            tcr_q       <= tcr_d;
            count_q     <= count_d;
            state_q     <= state_d;
            gmask_q     <= gmask_d;
            ext_latch_q <= ext_latch_d;
            map64_q     <= wr_cfg ? pwdata[timer_irq_pkg::CFG_MAP64K] : map64_q;
            in_prev_q   <= in_level;
            xrst_prev_q <= xrst_n_s;
            cyc_q       <= (cyc_q == timer_irq_pkg::CYC_DIV - 3'h1) ? 3'h0 : cyc_q + 3'h1;
        end
    end

    // Vector, interrupt line and core clock gate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_q     <= timer_irq_pkg::BASE_8K | 16'(timer_irq_pkg::VEC_RESET);
            vec_stb_q <= 1'b0;
            irq_q     <= 1'b0;
            run_q     <= 1'b1;
        end else begin
            vec_q     <= (svc_go || xrst_go) ? (vec_base | 16'(vec_low)) : vec_q;
            vec_stb_q <= svc_go || xrst_go;
            irq_q     <= (ext_latch_q || tmr_pend) && !gmask_q;
            run_q     <= (state_d == timer_irq_pkg::ST_RUN);
        end
    end

    // Bus pins: wait and stop park strobes low and the bus as input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            as_q <= 1'b0;
            ds_q <= 1'b0;
            rw_q <= 1'b1;
            oe_q <= 1'b0;
        end else begin
            as_q <= run_q && cyc_clk;
            ds_q <= run_q && !cyc_clk;
            rw_q <= !(run_q && acc && pwrite);
            oe_q <= run_q && acc && pwrite;
        end
    end

    // APB answer: one wait state, read data and error from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            ready_q <= acc && !ready_q;
            rdata_q <= (acc && !ready_q && !pwrite) ? rdata_d : rdata_q;
            err_q   <= acc && !ready_q && !mapped;
        end
    end

    assign prdata      = rdata_q;
    assign pready      = ready_q;
    assign pslverr     = err_q;
    assign core_irq    = irq_q;
    assign core_run    = run_q;
    assign vec_addr    = vec_q;
    assign vec_strobe  = vec_stb_q;
    assign addr_strobe = as_q;
    assign data_strobe = ds_q;
    assign bus_rw      = rw_q;
    assign bus_oe      = oe_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_req_on_zero: assert property (zero_evt && !xrst_go && !stop_go |=> tcr_q.tmr_req_flag)
        else $error("request flag not set at zero");
    a_irq_gating: assert property (core_irq |-> $past(!gmask_q))
        else $error("interrupt while globally masked");
    a_wait_vector: assert property (svc_tmr && !trap_go && state_q == timer_irq_pkg::ST_WAIT
        |=> vec_strobe && vec_addr[3:0] == 4'h6)
        else $error("wrong wait timer vector");
    a_count_wrap: assert property (tick && count_q == 8'h00 && !ld_cnt && !stop_go |=> count_q == 8'hff)
        else $error("counter did not wrap");
    a_count_hold: assert property (!tick && !ld_cnt && !stop_go |=> $stable(count_q))
        else $error("counter changed without input");
    a_clear_reads0: assert property (pready && !$past(pwrite) && $past(paddr) == 8'h00 |-> !prdata[3])
        else $error("prescaler clear bit read as one");
    a_stop_load: assert property (stop_go |=> count_q == 8'hf0 && tcr_q.tmr_mask_flag
        && !tcr_q.tmr_req_flag ##1 !core_run)
        else $error("stop did not load counter");
    a_wait_unmask: assert property (wait_go |=> !gmask_q && state_q == timer_irq_pkg::ST_WAIT
        ##1 !addr_strobe && !data_strobe && bus_rw)
        else $error("wait entry incorrect");
    a_ext_first: assert property (svc_ext && tmr_pend && !trap_go && !xrst_go
        |=> vec_addr[3:0] == 4'ha)
        else $error("external not served first");
    a_trap_vector: assert property (trap_go && !stop_go |=> vec_strobe && vec_addr[3:0] == 4'hc && gmask_q)
        else $error("trap vector wrong");
    a_ext_reset: assert property (xrst_go |=> gmask_q && vec_addr[3:0] == 4'he && tcr_q.tmr_mask_flag)
        else $error("external reset action wrong");

    c_timer_irq: cover property (svc_tmr && state_q == timer_irq_pkg::ST_RUN);
    c_wait_exit: cover property (state_q == timer_irq_pkg::ST_WAIT ##1 state_q == timer_irq_pkg::ST_RUN);
    c_wrap:      cover property (zero_evt ##[1:300] tick);
endmodule

// ### timer_irq_pkg.sv
// Purpose: Shared constants and types of the timer and interrupt block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Vectors are formed from a map base and a low nibble
package timer_irq_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_TCTRL  = 8'h00;
    localparam logic [7:0] ADDR_COUNT  = 8'h04;
    localparam logic [7:0] ADDR_SYS    = 8'h08;
    localparam logic [7:0] ADDR_VECTOR = 8'h0c;
    localparam logic [7:0] ADDR_CONFIG = 8'h10;

    // Control register field positions
    localparam int TC_REQ   = 7;
    localparam int TC_MASK  = 6;
    localparam int TC_SRC   = 5;
    localparam int TC_PIN   = 4;
    localparam int TC_CLEAR = 3;

    // System command bits (write one to act); CFG_MAP64K is the config register's map select bit
    localparam int CMD_WAIT   = 0;
    localparam int CMD_STOP   = 1;
    localparam int CMD_TRAP   = 2;
    localparam int CMD_DONE   = 3;
    localparam int CMD_CLI    = 4;
    localparam int CMD_SEI    = 5;
    localparam int CFG_MAP64K = 0;

    // Reset and load values
    localparam logic [7:0]  COUNT_LOAD = 8'hf0;
    localparam logic [15:0] BASE_8K    = 16'h1ff0;
    localparam logic [15:0] BASE_64K   = 16'hfff0;
    localparam logic [3:0]  VEC_TWAIT  = 4'h6;
    localparam logic [3:0]  VEC_TIMER  = 4'h8;
    localparam logic [3:0]  VEC_EXT    = 4'ha;
    localparam logic [3:0]  VEC_TRAP   = 4'hc;
    localparam logic [3:0]  VEC_RESET  = 4'he;

    // Instruction cycle in pclk cycles; strobe high for the first two of the five
    localparam logic [2:0] CYC_DIV = 3'h5;
    localparam logic [2:0] CYC_HI  = 3'h2;

    typedef struct packed {
        logic       tmr_req_flag;
        logic       tmr_mask_flag;
        logic       tmr_src_select;
        logic       tmr_pin_enable;
        logic       prescale_clear;
        logic [2:0] prescale_sel;
    } tcr_t;

    typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP} mode_t;

endpackage

// ### timer_irq_tb.sv
// Purpose: Self-checking bench for the timer and interrupt block
// Assumes: Slave answers each APB access within a bounded wait
// Notes:   Counter rates are measured as differences over exact spans
`timescale 1ns/1ps
module timer_irq_tb;
    localparam logic [7:0] CT = timer_irq_pkg::ADDR_TCTRL;
    localparam logic [7:0] CN = timer_irq_pkg::ADDR_COUNT;
    localparam logic [7:0] SY = timer_irq_pkg::ADDR_SYS;
    localparam logic [7:0] VE = timer_irq_pkg::ADDR_VECTOR;
    localparam logic [7:0] CF = timer_irq_pkg::ADDR_CONFIG;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic        ext_reset_n, irq_on, lvl, timer_pin, ext_irq_n;
    logic        core_irq, core_run, vec_strobe, addr_strobe, data_strobe, bus_rw, bus_oe;
    logic [7:0]  paddr, half;
    logic [15:0] vec_addr;
    logic [31:0] pwdata, prdata, r;
    int          n_mismatch, checks_done, cyc, n;

    timer_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_pin(timer_pin), .ext_irq_n(ext_irq_n),
        .ext_reset_n(ext_reset_n), .core_irq(core_irq), .core_run(core_run),
        .vec_addr(vec_addr), .vec_strobe(vec_strobe), .addr_strobe(addr_strobe),
        .data_strobe(data_strobe), .bus_rw(bus_rw), .bus_oe(bus_oe));
    pin_source far (.pclk(pclk), .half(half), .lvl(lvl), .irq_on(irq_on),
        .timer_pin(timer_pin), .ext_irq_n(ext_irq_n));

    always #4 pclk = ~pclk;

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, s, e);
        end
    endtask

    // One APB transfer; read data lands in r, error in se
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge pclk);
            k++;
        end
        if (k == 50) n_mismatch++;
        r = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(r, e);
    endtask

    // Decrements seen over exactly p clock cycles
    task automatic rate(input int p, input logic [7:0] e);
        logic [7:0] c0;
        acc(1'b0, CN, 32'h0);
        c0 = r[7:0];
        repeat (p - 4) @(posedge pclk);
        acc(1'b0, CN, 32'h0);
        chk({24'h0, c0 - r[7:0]}, {24'h0, e});
    endtask

    task automatic vec(input logic [15:0] e);
        repeat (2) @(posedge pclk);
        chk({16'h0, vec_addr}, {16'h0, e});
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {half, lvl, irq_on, n_mismatch, checks_done, cyc} = '0;
        ext_reset_n = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(CN, 32'hf0);
        rd(CT, 32'h40);
        rd(VE, 32'h1ffe);
        acc(1'b0, 8'h14, 32'h0);
        chk({31'h0, se}, 32'h1);
        chk(r, 32'h0);
        for (int k = 0; k < 8; k++) begin
            wr(CT, 32'h48 | k);
            rd(CT, 32'h40 | k);
            rate(20 * (1 << k), 8'h04);
        end
        lvl <= 1'b1;
        wr(CT, 32'h60);
        rate(100, 8'h00);
        wr(CT, 32'h50);
        rate(100, 8'h14);
        lvl <= 1'b0;
        repeat (4) @(posedge pclk);
        rate(100, 8'h00);
        half <= 8'h0a;
        wr(CT, 32'h70);
        rate(200, 8'h0a);
        half <= 8'h00;
        wr(CT, 32'h40);
        wr(CN, 32'h03);
        repeat (40) @(posedge pclk);
        rd(CT, 32'hc0);
        rate(50, 8'h0a);
        wr(CT, 32'h40);
        rd(CT, 32'h40);
        wr(CT, 32'he0);
        wr(SY, 32'h10);
        repeat (4) @(posedge pclk);
        chk({31'h0, core_irq}, 32'h0);
        wr(SY, 32'h20);
        wr(CT, 32'ha0);
        repeat (4) @(posedge pclk);
        chk({31'h0, core_irq}, 32'h0);
        wr(SY, 32'h10);
        repeat (4) @(posedge pclk);
        chk({31'h0, core_irq}, 32'h1);
        wr(SY, 32'h08);
        vec(16'h1ff8);
        rd(VE, 32'h1ff8);
        irq_on <= 1'b1;
        repeat (8) @(posedge pclk);
        irq_on <= 1'b0;
        wr(SY, 32'h10);
        wr(SY, 32'h08);
        vec(16'h1ffa);
        wr(SY, 32'h10);
        wr(SY, 32'h08);
        vec(16'h1ff8);
        wr(CT, 32'h00);
        chk({30'h0, bus_oe, bus_rw}, 32'h2);
        wr(CN, 32'h10);
        wr(SY, 32'h01);
        repeat (3) @(posedge pclk);
        chk({27'h0, core_run, addr_strobe, data_strobe, bus_rw, bus_oe}, 32'h2);
        rd(SY, 32'h02);
        n = 0;
        while (vec_strobe !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk({16'h0, vec_addr}, 32'h1ff6);
        wr(SY, 32'h04);
        vec(16'h1ffc);
        wr(CF, 32'h1);
        wr(SY, 32'h04);
        vec(16'hfffc);
        wr(CF, 32'h0);
        wr(CT, 32'ha0);
        wr(CN, 32'h11);
        wr(SY, 32'h02);
        repeat (5) @(posedge pclk);
        irq_on <= 1'b1;
        repeat (10) @(posedge pclk);
        irq_on <= 1'b0;
        repeat (10) @(posedge pclk);
        rd(CT, 32'h60);
        rd(CN, 32'hf0);
        wr(CT, 32'h25);
        wr(SY, 32'h10);
        ext_reset_n <= 1'b0;
        repeat (5) @(posedge pclk);
        ext_reset_n <= 1'b1;
        vec(16'h1ffe);
        rd(CT, 32'h65);
        rd(SY, 32'h01);
        test_done();
    end
endmodule

// ### tmr_prescaler.sv
// Purpose: Seven-bit prescaler with eight selectable taps
// Assumes: in_fall is a one-cycle pulse on a falling input edge
// Notes:   Not visible to software; only cleared
`timescale 1ns/1ps
module tmr_prescaler (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       in_fall,
    input  wire logic [2:0] sel,
    output      logic       tick
);
    logic [6:0] presc_q;
    logic [6:0] tap_mask;

    function automatic logic [6:0] low_mask(input logic [2:0] s);
        low_mask = 7'((8'h01 << s) - 8'h01);
    endfunction

    assign tap_mask = low_mask(sel);
    // Tap output falls when the selected low bits wrap to zero
    assign tick = in_fall && ((presc_q & tap_mask) == tap_mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= 7'h00;
        end else if (clear) begin
            presc_q <= 7'h00;
        end else if (in_fall) begin
            presc_q <= presc_q + 7'h01;
        end
    end

    a_presc_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clear |=> presc_q == 7'h00)
        else $error("prescaler not cleared");
endmodule
